// ==== common/pfc_pkg.sv ====
/*
 * Constants for the PHY function control register block: register index,
 * field positions, reset values and the local pause ability field layout.
 * Assumes a 32-bit classic Wishbone slave and a 16-bit register image.
 */
package pfc_pkg;

    // Register index; the byte address is four times this
    localparam logic [5:0]  PFC_REG_INDEX    = 6'h19;
    localparam int          PFC_ADR_W        = 8;
    localparam int          PFC_REG_W        = 16;

    // Field positions inside the register image
    localparam int          PFC_BIT_AUTO_X   = 15;
    localparam int          PFC_BIT_FORCE_X  = 14;
    localparam int          PFC_BIT_PAUSE_RX = 13;
    localparam int          PFC_BIT_PAUSE_TX = 12;
    localparam int          PFC_BIT_INJECT   = 11;
    localparam int          PFC_BIT_PRBS     = 10;
    localparam int          PFC_BIT_PASS     = 9;
    localparam int          PFC_BIT_RUN      = 8;
    localparam int          PFC_BIT_BYPASS   = 7;

    // Pause field of an ability advertisement: [1] asymmetric, [0] symmetric
    localparam int          PFC_ADV_PAUSE_LO = 10;
    localparam int          PFC_ADV_PAUSE_HI = 11;
    localparam int          PFC_PAUSE_SYM    = 0;
    localparam int          PFC_PAUSE_ASM    = 1;

    // Values after reset of the software-owned bits
    localparam logic        PFC_RST_FORCE_X  = 1'b0;
    localparam logic        PFC_RST_INJECT   = 1'b0;
    localparam logic        PFC_RST_PRBS     = 1'b0;
    localparam logic        PFC_RST_RUN      = 1'b0;
    localparam logic        PFC_RST_BYPASS   = 1'b0;
    localparam logic [31:0] PFC_RDATA_ZERO   = 32'h00000000;

    // Count of LED outputs passing through the stretch bypass
    localparam int          PFC_LED_N        = 3;

endpackage

// ==== common/pfc_pause_if.sv ====
/*
 * Interface carrying advertisement pause fields and the resolved pause
 * indications between the register block and the pause resolver.
 * Assumes both ends run in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

interface pfc_pause_if;
    logic [1:0] local_pause;
    logic [1:0] partner_pause;
    logic       full_duplex;
    logic       pause_rx;
    logic       pause_tx;

    // Register block drives the abilities and reads the result
    modport ctrl (output local_pause, output partner_pause, output full_duplex,
                  input pause_rx, input pause_tx);
    modport resolver (input local_pause, input partner_pause, input full_duplex,
                      output pause_rx, output pause_tx);
endinterface

`default_nettype wire

// ==== src/pfc_pause_resolve.sv ====
/*
 * Combinational pause resolution from local and partner pause abilities.
 * Assumes the caller registers the outputs before they reach software.
 */
`timescale 1ns/1ps
`default_nettype none

module pfc_pause_resolve
(
    // Abilities in, resolved pause out
    pfc_pause_if.resolver pause_if
);
    import pfc_pkg::*;

    logic sym_l;
    logic asm_l;
    logic sym_p;
    logic asm_p;

    // Field aliases for readability
    assign sym_l = pause_if.local_pause[PFC_PAUSE_SYM];
    assign asm_l = pause_if.local_pause[PFC_PAUSE_ASM];
    assign sym_p = pause_if.partner_pause[PFC_PAUSE_SYM];
    assign asm_p = pause_if.partner_pause[PFC_PAUSE_ASM];

    // Standard resolution table, gated off unless full duplex was negotiated
    always_comb
    begin
        pause_if.pause_tx = 1'b0;
        pause_if.pause_rx = 1'b0;
        if (pause_if.full_duplex)
        begin
            if (sym_l && sym_p)
            begin
                pause_if.pause_tx = 1'b1;
                pause_if.pause_rx = 1'b1;
            end
            else if (!sym_l && asm_l && sym_p && asm_p)
            begin
                pause_if.pause_tx = 1'b1;
            end
            else if (sym_l && asm_l && !sym_p && asm_p)
            begin
                pause_if.pause_rx = 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ==== src/pfc_phy_function_control.sv ====
/*
 * Bits 15 to 7 of the PHY function control register behind a classic Wishbone
 * slave: crossover control, resolved pause status, packet self-test control
 * and LED stretch bypass. Bits 6 to 0 read as zero here.
 * Assumes one 125 MHz clock, synchronous active-high reset, and a self-test
 * engine and LED stretcher outside that consume the control outputs.
 */
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module pfc_phy_function_control
(
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Classic Wishbone slave
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [pfc_pkg::PFC_ADR_W-1:0] adr_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [31:0]                   dat_i,
    output logic      [31:0]                   dat_o,
    output logic                               ack_o,
    // Strap and negotiation results
    input  wire logic                          auto_crossover_strap_i,
    input  wire logic [15:0]                   local_ability_advert_i,
    input  wire logic [15:0]                   partner_ability_advert_i,
    input  wire logic                          hcd_full_duplex_i,
    // Self-test engine
    input  wire logic                          selftest_error_i,
    output logic                               selftest_run_o,
    output logic                               prbs_length_select_o,
    output logic                               selftest_error_inject_o,
    // Media pair control
    output logic                               auto_crossover_enable_o,
    output logic                               force_crossover_o,
    // LEDs
    input  wire logic [pfc_pkg::PFC_LED_N-1:0] led_raw_i,
    input  wire logic [pfc_pkg::PFC_LED_N-1:0] led_stretched_i,
    output logic      [pfc_pkg::PFC_LED_N-1:0] led_o
);
    import pfc_pkg::*;

    pfc_pause_if pause_if ();

    logic                 ack_q, ack_d;
    logic [31:0]          dat_q, dat_d;
    logic                 auto_x_q, auto_x_d;
    logic                 force_x_q, force_x_d;
    logic                 inject_q, inject_d;
    logic                 inject_pulse_q, inject_pulse_d;
    logic                 prbs_q, prbs_d;
    logic                 run_q, run_d;
    logic                 fail_q, fail_d;
    logic                 bypass_q, bypass_d;
    logic                 pause_rx_q, pause_rx_d;
    logic                 pause_tx_q, pause_tx_d;
    logic [PFC_LED_N-1:0] led_q, led_d;
    logic                 hit;
    logic                 wr_hi;
    logic                 wr_lo;
    logic [15:0]          image;

    // Pause resolver fed from the advertisement pause fields
    assign pause_if.local_pause   = local_ability_advert_i[PFC_ADV_PAUSE_HI:PFC_ADV_PAUSE_LO];
    assign pause_if.partner_pause = partner_ability_advert_i[PFC_ADV_PAUSE_HI:PFC_ADV_PAUSE_LO];
    assign pause_if.full_duplex   = hcd_full_duplex_i;

    pfc_pause_resolve u_resolve
    (
        .pause_if (pause_if)
    );

    // Decode; a write lands at the edge where the master sees ack
    assign hit   = (adr_i[PFC_ADR_W-1:2] == PFC_REG_INDEX);
    assign wr_hi = cyc_i && stb_i && we_i && ack_q && hit && sel_i[1];
    assign wr_lo = cyc_i && stb_i && we_i && ack_q && hit && sel_i[0];

    // Read image; status bits come from live state, not from writes
    always_comb
    begin
        image                   = 16'h0000;
        image[PFC_BIT_AUTO_X]   = auto_x_q;
        image[PFC_BIT_FORCE_X]  = force_x_q;
        image[PFC_BIT_PAUSE_RX] = pause_rx_q;
        image[PFC_BIT_PAUSE_TX] = pause_tx_q;
        image[PFC_BIT_INJECT]   = inject_q;
        image[PFC_BIT_PRBS]     = prbs_q;
        image[PFC_BIT_PASS]     = run_q && !fail_q;
        image[PFC_BIT_RUN]      = run_q;
        image[PFC_BIT_BYPASS]   = bypass_q;
    end

    // Bus answer: ack one cycle after the request, dropped the cycle after
    always_comb
    begin
        ack_d = cyc_i && stb_i && !ack_q;
        dat_d = dat_q;
        if (ack_d)
        begin
            dat_d = hit ? {16'h0000, image} : PFC_RDATA_ZERO;
        end
    end

    // Control bits: software writes, self-clearing inject, latched failure
    always_comb
    begin
        auto_x_d       = auto_x_q;
        force_x_d      = force_x_q;
        inject_d       = inject_q;
        prbs_d         = prbs_q;
        run_d          = run_q;
        bypass_d       = bypass_q;
        inject_pulse_d = 1'b0;
        // Inject fires once and then reads back zero
        if (inject_q)
        begin
            inject_pulse_d = 1'b1;
            inject_d       = 1'b0;
        end
        if (wr_hi)
        begin
            auto_x_d  = dat_i[PFC_BIT_AUTO_X];
            force_x_d = dat_i[PFC_BIT_FORCE_X];
            prbs_d    = dat_i[PFC_BIT_PRBS];
            run_d     = dat_i[PFC_BIT_RUN];
            if (dat_i[PFC_BIT_INJECT] && !inject_q)
            begin
                inject_d = 1'b1;
            end
        end
        if (wr_lo)
        begin
            bypass_d = dat_i[PFC_BIT_BYPASS];
        end
        // An error in the same cycle as a stop still counts, then clears
        fail_d = run_q && (fail_q || selftest_error_i);
        pause_rx_d = pause_if.pause_rx;
        pause_tx_d = pause_if.pause_tx;
        led_d      = bypass_q ? led_raw_i : led_stretched_i;
    end

    // Registers; the strap is captured while reset is held
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q          <= 1'b0;
            dat_q          <= PFC_RDATA_ZERO;
            auto_x_q       <= auto_crossover_strap_i;
            force_x_q      <= PFC_RST_FORCE_X;
            inject_q       <= PFC_RST_INJECT;
            inject_pulse_q <= 1'b0;
            prbs_q         <= PFC_RST_PRBS;
            run_q          <= PFC_RST_RUN;
            fail_q         <= 1'b0;
            bypass_q       <= PFC_RST_BYPASS;
            pause_rx_q     <= 1'b0;
            pause_tx_q     <= 1'b0;
            led_q          <= '0;
        end
        else
        begin
            ack_q          <= ack_d;
            dat_q          <= dat_d;
            auto_x_q       <= auto_x_d;
            force_x_q      <= force_x_d;
            inject_q       <= inject_d;
            inject_pulse_q <= inject_pulse_d;
            prbs_q         <= prbs_d;
            run_q          <= run_d;
            fail_q         <= fail_d;
            bypass_q       <= bypass_d;
            pause_rx_q     <= pause_rx_d;
            pause_tx_q     <= pause_tx_d;
            led_q          <= led_d;
        end
    end

    // Outputs, all from flip-flops, the handshake included
    assign ack_o                   = ack_q;
    assign dat_o                   = dat_q;
    assign auto_crossover_enable_o = auto_x_q;
    assign force_crossover_o       = force_x_q;
    assign prbs_length_select_o    = prbs_q;
    assign selftest_run_o          = run_q;
    assign selftest_error_inject_o = inject_pulse_q;
    assign led_o                   = led_q;
endmodule

`default_nettype wire

// ==== verif/pfc_phy_function_control_assertions.sv ====
/*
 * Concurrent checks on the function control register block ports.
 * Assumes one clock, synchronous reset and one-cycle Wishbone answers.
 */
`timescale 1ns/1ps
`default_nettype none

module pfc_phy_function_control_assertions
    import pfc_pkg::*;
(
    // Clock, reset and bus
    input wire logic                          clk_i,
    input wire logic                          rst_i,
    input wire logic                          we_i,
    input wire logic [pfc_pkg::PFC_ADR_W-1:0] adr_i,
    input wire logic [3:0]                    sel_i,
    input wire logic [31:0]                   dat_i,
    input wire logic [31:0]                   dat_o,
    input wire logic                          ack_o,
    // Status and control
    input wire logic                          hcd_full_duplex_i,
    input wire logic                          selftest_run_o,
    input wire logic                          selftest_error_inject_o,
    input wire logic                          auto_crossover_enable_o,
    input wire logic                          force_crossover_o,
    // LEDs
    input wire logic [pfc_pkg::PFC_LED_N-1:0] led_raw_i,
    input wire logic [pfc_pkg::PFC_LED_N-1:0] led_stretched_i,
    input wire logic [pfc_pkg::PFC_LED_N-1:0] led_o
);
    // Decoded answered accesses; only the upper lane matters here
    wire hit = adr_i[7:2] == PFC_REG_INDEX;
    wire wr  = ack_o && we_i && sel_i[1] && hit;
    wire rd  = ack_o && !we_i && hit;

    // Bypass bit as software last wrote it, so the LED check knows which source is due
    logic bypass_seen_q;
    logic bypass_seen_d;

    always_comb
    begin
        bypass_seen_d = bypass_seen_q;
        if (ack_o && we_i && sel_i[0] && hit)
        begin
            bypass_seen_d = dat_i[PFC_BIT_BYPASS];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bypass_seen_q <= PFC_RST_BYPASS;
        end
        else
        begin
            bypass_seen_q <= bypass_seen_d;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_auto_x_write: assert property (wr |=> auto_crossover_enable_o == $past(dat_i[15]))
        else $error("auto crossover not written");
    a_force_x_write: assert property (wr |=> force_crossover_o == $past(dat_i[14]))
        else $error("force crossover not written");
    a_run_write: assert property (wr |=> selftest_run_o == $past(dat_i[8]))
        else $error("self-test run not written");
    a_inject_pulse: assert property (wr && dat_i[11] |-> ##2 selftest_error_inject_o)
        else $error("inject pulse missing");
    a_inject_single: assert property (selftest_error_inject_o |=> !selftest_error_inject_o)
        else $error("inject pulse too long");
    a_pause_half_dup: assert property (rd && !$past(hcd_full_duplex_i, 2) |-> dat_o[13:12] == 2'b00)
        else $error("pause set without full duplex");
    a_pass_idle: assert property (rd && !$past(selftest_run_o) |-> !dat_o[9])
        else $error("pass shown while stopped");
    a_unmapped_zero: assert property (ack_o && !we_i && !hit |-> dat_o == PFC_RDATA_ZERO)
        else $error("unmapped read not zero");
    a_led_source: assert property (!$past(rst_i)
        |-> led_o == ($past(bypass_seen_q) ? $past(led_raw_i) : $past(led_stretched_i)))
        else $error("led output does not follow the bypass bit");
endmodule

bind pfc_phy_function_control pfc_phy_function_control_assertions u_chk (.clk_i, .rst_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .hcd_full_duplex_i, .selftest_run_o, .selftest_error_inject_o,
    .auto_crossover_enable_o, .force_crossover_o, .led_raw_i, .led_stretched_i, .led_o);

`default_nettype wire

// ==== verif/pfc_phy_function_control_bench.sv ====
/*
 * Self-checking bench for the function control register block.
 * Assumes the block answers each Wishbone request with one ack pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module pfc_phy_function_control_bench;
    import pfc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic        auto_crossover_strap_i = 1'b1;
    logic [15:0] local_ability_advert_i = 16'h0000;
    logic [15:0] partner_ability_advert_i = 16'h0000;
    logic        hcd_full_duplex_i = 1'b0;
    logic        selftest_error_i = 1'b0;
    logic [2:0]  led_raw_i = 3'h5;
    logic [2:0]  led_stretched_i = 3'h2;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        selftest_run_o;
    logic        prbs_length_select_o;
    logic        selftest_error_inject_o;
    logic        auto_crossover_enable_o;
    logic        force_crossover_o;
    logic [2:0]  led_o;
    wire  [3:0]  ctl_seen = {auto_crossover_enable_o, force_crossover_o, prbs_length_select_o, selftest_run_o};
    logic [31:0] r;
    int          failures = 0;
    int          checks_done = 0;
    int          pulses = 0;
    logic [15:0] la [5] = '{16'h0400, 16'h0800, 16'h0C00, 16'h0000, 16'h0400};
    logic [15:0] pa [5] = '{16'h0400, 16'h0C00, 16'h0800, 16'h0C00, 16'h0400};
    logic [15:0] pe [5] = '{16'h3000, 16'h1000, 16'h2000, 16'h0000, 16'h0000};

    pfc_phy_function_control dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .auto_crossover_strap_i, .local_ability_advert_i, .partner_ability_advert_i,
        .hcd_full_duplex_i, .selftest_error_i, .selftest_run_o, .prbs_length_select_o,
        .selftest_error_inject_o, .auto_crossover_enable_o, .force_crossover_o, .led_raw_i,
        .led_stretched_i, .led_o);

    // 125 MHz clock
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    // Count inject pulses so a doubled pulse shows up
    always @(posedge clk_i)
    begin
        if (selftest_error_inject_o === 1'b1)
            pulses++;
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; holds everything until ack is sampled high, only the watchdog ends a hang
    task wb(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [15:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {16'h0000, d};
        do
        begin
            @(posedge clk_i);
        end
        while (ack_o !== 1'b1);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task rd(input logic [15:0] m, input logic [15:0] e);
        wb(8'h64, 1'b0, 4'h3, 16'h0000);
        check(r[15:0] & m, e);
    endtask

    task print_verdict;
        $display("failures %0d checks %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(16'hFFFF, 16'h8000);
        wb(8'h64, 1'b1, 4'h3, 16'h0000);
        rd(16'hFFFF, 16'h0000);
        // Auto-negotiation counts as enabled here, so software may turn automatic crossover on
        wb(8'h64, 1'b1, 4'h3, 16'hC480);
        rd(16'hFFFF, 16'hC480);
        check({12'h000, ctl_seen}, 16'h000E);
        check({13'h0, led_o}, 16'h0005);
        wb(8'h64, 1'b1, 4'h3, 16'h3200);
        rd(16'hFFFF, 16'h0000);
        check({13'h0, led_o}, 16'h0002);
        wb(8'h64, 1'b1, 4'h1, 16'hFFFF);
        rd(16'hFFFF, 16'h0080);
        wb(8'h68, 1'b1, 4'h3, 16'hFFFF);
        rd(16'hFFFF, 16'h0080);
        wb(8'h60, 1'b0, 4'h3, 16'h0000);
        check(r[15:0], 16'h0000);
        // Pause resolution cases, last one in half duplex
        for (int i = 0; i < 5; i++)
        begin
            local_ability_advert_i <= la[i];
            partner_ability_advert_i <= pa[i];
            hcd_full_duplex_i <= (i < 4);
            repeat (2) @(posedge clk_i);
            rd(16'h3000, pe[i]);
        end
        wb(8'h64, 1'b1, 4'h3, 16'h0100);
        rd(16'h0200, 16'h0200);
        wb(8'h64, 1'b1, 4'h3, 16'h0900);
        rd(16'h0A00, 16'h0200);
        repeat (4) @(posedge clk_i);
        check(pulses[15:0], 16'h0001);
        selftest_error_i <= 1'b1;
        @(posedge clk_i);
        selftest_error_i <= 1'b0;
        rd(16'h0200, 16'h0000);
        rd(16'h0200, 16'h0000);
        wb(8'h64, 1'b1, 4'h3, 16'h0000);
        wb(8'h64, 1'b1, 4'h3, 16'h0100);
        rd(16'h0200, 16'h0200);
        // Second reset with the strap low; every bit must return to its value after reset
        auto_crossover_strap_i <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(16'hFFFF, 16'h0000);
        check({12'h000, ctl_seen}, 16'h0000);
        check({13'h0, led_o}, 16'h0002);
        check(pulses[15:0], 16'h0001);
        print_verdict;
    end

    // Watchdog well beyond the hundred or so cycles the tests need
    initial
    begin
        #100000;
        failures++;
        print_verdict;
    end
endmodule

`default_nettype wire
